// >>> hdl/nvm_cfg_status.sv
// Configuration, parameter, interrupt and status registers of the flash controller
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module nvm_cfg_status
   import nvm_cfg_pkg::*;
#(
   parameter logic [11:0] EEP_PAGES  = 12'h000,
   parameter logic [2:0]  PSZ_CODE   = 3'h0,
   parameter logic [15:0] MAIN_PAGES = 16'h0080
)(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        busy_i,
   input  wire logic        mem_err_i,
   input  wire logic        lock_err_i,
   input  wire logic        cmd_err_i,
   input  wire logic        buf_load_i,
   input  wire logic        buf_last_i,
   input  wire logic        page_write_i,
   input  wire logic        buf_clear_i,
   input  wire logic        cmd_prm_set_i,
   input  wire logic        cmd_prm_clr_i,
   input  wire logic        sleep_i,
   input  wire logic        mem_access_i,
   input  wire logic        secure_i,
   output logic             auto_write_o,
   output logic             power_reduced_o,
   output logic      [3:0]  wait_states_o,
   output logic             manual_write_o,
   output logic             irq_o
);
   logic [31:0] control_b_settings_q;
   logic [1:0]  ien_q;
   logic        err_q;
   logic [2:0]  errs_q;
   logic        load_q;
   logic        prm_q;
   logic        sleep_q;
   logic        auto_q;
   logic [1:0]  sel;
   logic [15:0] status;
   logic [1:0]  flags;
   logic        any_err;

   function automatic logic wr_at(input logic [7:0] ofs);
      wr_at = wr_i && (addr_i == ofs);
   endfunction

   assign sel      = control_b_settings_q[SLEEP_LSB +: 2];
   assign any_err  = mem_err_i | lock_err_i | cmd_err_i;
   assign flags    = {err_q, ~busy_i};
   assign status   = {7'h00, secure_i, 3'h0, errs_q, load_q, prm_q};

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         control_b_settings_q <= CONTROL_B_SETTINGS_RST;
      else if (wr_at(CONTROL_B_SETTINGS_OFS))
         control_b_settings_q <= wdata_i & CONTROL_B_SETTINGS_MASK;
   end
   assign wait_states_o  = control_b_settings_q[RWS_LSB +: 4];
   assign manual_write_o = control_b_settings_q[MANUAL_WRITE_SEL_BIT];

   // Last-word write only triggers programming when manual mode is off
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         auto_q <= 1'b0;
      else
         auto_q <= buf_load_i && buf_last_i && !control_b_settings_q[MANUAL_WRITE_SEL_BIT];
   end
   assign auto_write_o = auto_q;

   // Shared enable state for set and clear views
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         ien_q <= 2'h0;
      else if (wr_at(IENSET_OFS))
         ien_q <= ien_q | wdata_i[1:0];
      else if (wr_at(IENCLR_OFS))
         ien_q <= ien_q & ~wdata_i[1:0];
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         err_q <= 1'b0;
      else if (any_err)
         err_q <= 1'b1;
      else if (wr_at(IFLAG_OFS) && wdata_i[ERR_BIT])
         err_q <= 1'b0;
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         errs_q <= 3'h0;
      else if (wr_at(STATUS_OFS))
         errs_q <= (errs_q & ~wdata_i[ST_MEM:ST_CMD])
                   | {mem_err_i, lock_err_i, cmd_err_i};
      else
         errs_q <= errs_q | {mem_err_i, lock_err_i, cmd_err_i};
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         load_q <= 1'b0;
      else if (buf_load_i)
         load_q <= 1'b1;
      else if (page_write_i || buf_clear_i || auto_q)
         load_q <= 1'b0;
      else if (wr_at(STATUS_OFS) && wdata_i[ST_LOAD])
         load_q <= 1'b0;
   end

   // Power reduction: command, sleep entry, sleep exit or first access
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         sleep_q <= 1'b0;
      else
         sleep_q <= sleep_i;
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         prm_q <= 1'b0;
      else if (cmd_prm_set_i)
         prm_q <= 1'b1;
      else if (cmd_prm_clr_i)
         prm_q <= 1'b0;
      else if (sleep_i && !sleep_q && (sel == SLP_ACCESS || sel == SLP_INSTANT))
         prm_q <= 1'b1;
      else if (!sleep_i && sleep_q && sel == SLP_INSTANT)
         prm_q <= 1'b0;
      else if (mem_access_i)
         prm_q <= 1'b0;
   end
   assign power_reduced_o = prm_q;

   assign irq_o = |(flags & ien_q);

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_i)
      begin
         case (addr_i)
            CONTROL_B_SETTINGS_OFS:  rdata_o <= control_b_settings_q;
            MEMORY_GEOMETRY_PARAMS_OFS:  rdata_o <= {EEP_PAGES, 1'b0, PSZ_CODE, MAIN_PAGES};
            IENCLR_OFS: rdata_o <= {30'h0, ien_q};
            IENSET_OFS: rdata_o <= {30'h0, ien_q};
            IFLAG_OFS:  rdata_o <= {30'h0, flags};
            STATUS_OFS: rdata_o <= {16'h0000, status};
            default:    rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   a_enable_share: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_at(IENSET_OFS) && wdata_i[0] |=> ien_q[0])
      else $error("enable set lost");
   a_enable_clr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_at(IENCLR_OFS) && !wr_at(IENSET_OFS) && wdata_i[1] |=> !ien_q[1])
      else $error("enable clear lost");
   a_err_sticky: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      any_err |=> err_q)
      else $error("error flag not set");
   a_ready_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      flags[RDY_BIT] == !busy_i)
      else $error("ready flag wrong");
   a_irq_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      irq_o == ((err_q && ien_q[1]) || (!busy_i && ien_q[0])))
      else $error("irq mismatch");
   a_auto_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      buf_load_i && buf_last_i && control_b_settings_q[MANUAL_WRITE_SEL_BIT] |=> !auto_write_o)
      else $error("auto write in manual mode");
   a_load_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      buf_load_i |=> load_q)
      else $error("load bit not set");
   a_sleep_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      sel == SLP_OFF && !prm_q && !cmd_prm_set_i |=> !prm_q)
      else $error("power down while disabled");
   a_errs_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      errs_q[2] && !wr_at(STATUS_OFS) |=> errs_q[2])
      else $error("memory error lost");

   // All checks below share the system clock and reset
   default clocking chk_cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Sleep edges as the power logic sees them
   sequence s_sleep_enter;
      sleep_i && !sleep_q;
   endsequence

   sequence s_sleep_leave;
      !sleep_i && sleep_q;
   endsequence

   // Commands outrank sleep, so quiet commands are a precondition
   sequence s_cmd_quiet;
      !cmd_prm_set_i && !cmd_prm_clr_i;
   endsequence

   sequence s_memory_geometry_params_read;
      rd_i && (addr_i == MEMORY_GEOMETRY_PARAMS_OFS);
   endsequence

   a_access_enter: assert property (
      s_sleep_enter ##0 s_cmd_quiet ##0 (sel == SLP_ACCESS)
      |=> prm_q)
      else $error("no power down on sleep entry");

   a_access_hold: assert property (
      prm_q ##0 s_sleep_leave ##0 s_cmd_quiet
      ##0 (sel == SLP_ACCESS && !mem_access_i)
      |=> prm_q)
      else $error("woke before first access");

   a_access_wake: assert property (
      mem_access_i && !(sleep_i && !sleep_q) ##0 s_cmd_quiet
      |=> !prm_q)
      else $error("access did not wake");

   a_instant_enter: assert property (
      s_sleep_enter ##0 s_cmd_quiet ##0 (sel == SLP_INSTANT)
      |=> prm_q)
      else $error("no power down on sleep entry");

   a_instant_exit: assert property (
      s_sleep_leave ##0 s_cmd_quiet ##0 (sel == SLP_INSTANT)
      |=> !prm_q)
      else $error("no wake on sleep exit");

   a_auto_fire: assert property (
      buf_load_i && buf_last_i && !manual_write_o
      |=> auto_write_o)
      else $error("auto write missing");

   a_auto_pulse: assert property (
      auto_write_o && !(buf_load_i && buf_last_i)
      |=> !auto_write_o)
      else $error("auto write too long");

   a_manual_write: assert property (
      wr_at(CONTROL_B_SETTINGS_OFS)
      |=> manual_write_o == $past(wdata_i[MANUAL_WRITE_SEL_BIT]))
      else $error("manual bit not written");

   a_wait_write: assert property (
      wr_at(CONTROL_B_SETTINGS_OFS)
      |=> wait_states_o == $past(wdata_i[RWS_LSB +: 4]))
      else $error("wait states not written");

   a_ctrl_hold: assert property (
      !wr_at(CONTROL_B_SETTINGS_OFS)
      |=> $stable(control_b_settings_q))
      else $error("settings changed without write");

   a_eep_pages: assert property (
      s_memory_geometry_params_read
      |=> rdata_o[31:EEP_LSB] == EEP_PAGES)
      else $error("emulated page count wrong");

   a_page_size: assert property (
      s_memory_geometry_params_read
      |=> rdata_o[PSZ_LSB +: 3] == PSZ_CODE)
      else $error("page size code wrong");

   a_main_pages: assert property (
      s_memory_geometry_params_read
      |=> rdata_o[15:0] == MAIN_PAGES)
      else $error("main page count wrong");

   a_enclr_read: assert property (
      rd_i && (addr_i == IENCLR_OFS)
      |=> rdata_o[1:0] == $past(ien_q))
      else $error("enable clear view wrong");

   a_enset_read: assert property (
      rd_i && (addr_i == IENSET_OFS)
      |=> rdata_o[1:0] == $past(ien_q))
      else $error("enable set view wrong");

   a_enset_err: assert property (
      wr_at(IENSET_OFS) && wdata_i[1]
      |=> ien_q[1])
      else $error("error enable not set");

   a_enable_keep: assert property (
      !wr_at(IENSET_OFS) && !wr_at(IENCLR_OFS)
      |=> $stable(ien_q))
      else $error("enables changed without write");

   a_err_clear: assert property (
      !any_err && wr_at(IFLAG_OFS) && wdata_i[ERR_BIT]
      |=> !err_q)
      else $error("error flag not cleared");

   a_err_hold: assert property (
      err_q && !(wr_at(IFLAG_OFS) && wdata_i[ERR_BIT])
      |=> err_q)
      else $error("error flag lost");

   a_ready_read: assert property (
      rd_i && (addr_i == IFLAG_OFS)
      |=> rdata_o[RDY_BIT] == !$past(busy_i))
      else $error("ready flag read wrong");

   a_lock_keep: assert property (
      errs_q[1] && !wr_at(STATUS_OFS)
      |=> errs_q[1])
      else $error("lock error lost");

   a_cmd_keep: assert property (
      errs_q[0] && !wr_at(STATUS_OFS)
      |=> errs_q[0])
      else $error("command error lost");

   a_mem_clear: assert property (
      wr_at(STATUS_OFS) && wdata_i[ST_MEM] && !mem_err_i
      |=> !errs_q[2])
      else $error("memory error not cleared");

   a_load_clear: assert property (
      !buf_load_i && (page_write_i || buf_clear_i)
      |=> !load_q)
      else $error("load bit not cleared");

   a_load_hold: assert property (
      load_q && !buf_load_i && !page_write_i && !buf_clear_i
      && !auto_write_o && !(wr_at(STATUS_OFS) && wdata_i[ST_LOAD])
      |=> load_q)
      else $error("load bit lost");

   a_prm_set: assert property (
      cmd_prm_set_i
      |=> power_reduced_o)
      else $error("power down command ignored");

   a_prm_clr: assert property (
      cmd_prm_clr_i && !cmd_prm_set_i
      |=> !power_reduced_o)
      else $error("wake command ignored");

   a_prm_read: assert property (
      rd_i && (addr_i == STATUS_OFS)
      |=> rdata_o[ST_PRM] == $past(prm_q))
      else $error("power state read wrong");

   a_irq_masked: assert property (
      ien_q == 2'h0
      |-> !irq_o)
      else $error("interrupt while all masked");
endmodule
`default_nettype wire

// >>> inc/nvm_cfg_pkg.sv
// Constants for the memory controller configuration and status block
// How it works
// - Sleep select 0: power down on sleep, wake on first memory access.
// - Sleep select 1: power down on sleep, wake when sleep ends.
// - Sleep select 3 disables automatic power down; value 2 is reserved.
// - Manual write clear: last page buffer word write starts page programming.
// - Manual write set, the reset value: programming only by explicit command.
// - Four-bit read wait states, 0 to 15, reset to zero.
// - Parameter bits 31:20 report emulated EEPROM page count.
// - Parameter bits 18:16 give page size code, 8 to 1024 bytes.
// - Parameter bits 15:0 report main array page count.
// - Enable clear: write one disables, zero ignored, reads current enables.
// - Enable set: write one enables, zero ignored, reads current enables.
// - Enable set and clear share one enable state.
// - Error flag bit 1 set on any error, cleared by writing one.
// - Ready flag bit 0 is zero while busy, one when ready.
// - Status error bits stick until software writes one.
// - Buffer loaded bit sets on a load, clears on write or buffer clear.
// - Power reduced bit shows current power down state.
package nvm_cfg_pkg;
   localparam logic [7:0]  CONTROL_B_SETTINGS_OFS  = 8'h04;
   localparam logic [7:0]  MEMORY_GEOMETRY_PARAMS_OFS  = 8'h08;
   localparam logic [7:0]  IENCLR_OFS = 8'h0c;
   localparam logic [7:0]  IENSET_OFS = 8'h10;
   localparam logic [7:0]  IFLAG_OFS  = 8'h14;
   localparam logic [7:0]  STATUS_OFS = 8'h18;
   localparam int          SLEEP_LSB  = 8;
   localparam int          MANUAL_WRITE_SEL_BIT   = 7;
   localparam int          RWS_LSB    = 1;
   localparam logic [1:0]  SLP_ACCESS  = 2'h0;
   localparam logic [1:0]  SLP_INSTANT = 2'h1;
   localparam logic [1:0]  SLP_OFF     = 2'h3;
   localparam logic [31:0] CONTROL_B_SETTINGS_RST  = 32'h0000_0080;
   localparam logic [31:0] CONTROL_B_SETTINGS_MASK = 32'h0000_039e;
   localparam int          EEP_LSB    = 20;
   localparam int          PSZ_LSB    = 16;
   localparam int          ERR_BIT    = 1;
   localparam int          RDY_BIT    = 0;
   localparam int          ST_SEC     = 8;
   localparam int          ST_MEM     = 4;
   localparam int          ST_LOCK    = 3;
   localparam int          ST_CMD     = 2;
   localparam int          ST_LOAD    = 1;
   localparam int          ST_PRM     = 0;
endpackage

// >>> sim/tb_nvm_cfg_status.sv
// Self-checking bench for the configuration and status registers
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_cfg_status
   import nvm_cfg_pkg::*;
;
   typedef struct packed
   {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } row_s;
   logic        mclk_i     = 1'b0;
   logic        sys_rst_i  = 1'b1;
   logic [7:0]  addr_i     = 8'h00;
   logic [31:0] wdata_i    = 32'h0;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic        busy_i     = 1'b0;
   logic        buf_last_i = 1'b0;
   logic        sleep_i    = 1'b0;
   logic [8:0]  ev         = 9'h000;
   logic [31:0] rdata_o;
   logic        auto_write_o;
   logic        power_reduced_o;
   logic        manual_write_o;
   logic        irq_o;
   logic [3:0]  wait_states_o;
   logic [31:0] rv;
   int          n_mismatch   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   row_s        rows [7];
   nvm_cfg_status dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .busy_i(busy_i), .mem_err_i(ev[0]),
      .lock_err_i(ev[1]), .cmd_err_i(ev[2]), .buf_load_i(ev[3]),
      .buf_last_i(buf_last_i), .page_write_i(ev[4]), .buf_clear_i(ev[5]),
      .cmd_prm_set_i(ev[6]), .cmd_prm_clr_i(ev[7]), .sleep_i(sleep_i),
      .mem_access_i(ev[8]), .secure_i(1'b1), .auto_write_o(auto_write_o),
      .power_reduced_o(power_reduced_o), .wait_states_o(wait_states_o),
      .manual_write_o(manual_write_o), .irq_o(irq_o));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      rv = rdata_o;
   endtask
   // Events are one-cycle pulses; outputs read once they have settled
   task automatic pulse(input logic [8:0] m);
      @(posedge mclk_i);
      ev <= m;
      @(posedge mclk_i);
      ev <= 9'h000;
      @(negedge mclk_i);
   endtask
   task automatic sl(input logic v);
      @(posedge mclk_i);
      sleep_i <= v;
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      forever #5 mclk_i = ~mclk_i;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial
   begin
      rows[0] = '{1'b0, MEMORY_GEOMETRY_PARAMS_OFS, 32'h0, 32'h0000_0080};
      rows[1] = '{1'b0, CONTROL_B_SETTINGS_OFS, 32'h0, CONTROL_B_SETTINGS_RST};
      rows[2] = '{1'b1, CONTROL_B_SETTINGS_OFS, 32'hffff_ffff, CONTROL_B_SETTINGS_MASK};
      rows[3] = '{1'b1, IENSET_OFS, 32'h3, 32'h3};
      rows[4] = '{1'b1, IENCLR_OFS, 32'h1, 32'h2};
      rows[5] = '{1'b0, IENSET_OFS, 32'h0, 32'h2};
      rows[6] = '{1'b1, 8'h30, 32'hffff_ffff, 32'h0};
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      foreach (rows[k])
      begin
         if (rows[k].wr)
            wr(rows[k].a, rows[k].d);
         rd(rows[k].a);
         chk(rv, rows[k].e);
      end
      chk(32'(wait_states_o), 32'hf);
      chk(32'(manual_write_o), 32'h1);
      $display("table done");
      wr(CONTROL_B_SETTINGS_OFS, 32'h300);
      @(posedge mclk_i);
      buf_last_i <= 1'b1;
      chk(32'(manual_write_o), 32'h0);
      pulse(9'h008);
      chk(32'(auto_write_o), 32'h1);
      @(posedge mclk_i);
      buf_last_i <= 1'b0;
      pulse(9'h008);
      chk(32'(auto_write_o), 32'h0);
      rd(STATUS_OFS);
      chk(rv, 32'h102);
      pulse(9'h010);
      rd(STATUS_OFS);
      chk(rv, 32'h100);
      pulse(9'h008);
      pulse(9'h020);
      rd(STATUS_OFS);
      chk(rv, 32'h100);
      wr(CONTROL_B_SETTINGS_OFS, 32'h380);
      @(posedge mclk_i);
      buf_last_i <= 1'b1;
      pulse(9'h008);
      chk(32'(auto_write_o), 32'h0);
      @(posedge mclk_i);
      buf_last_i <= 1'b0;
      pulse(9'h020);
      $display("page write done");
      for (int i = 0; i < 3; i++)
      begin
         pulse(9'(1 << i));
         chk(32'(irq_o), 32'h1);
         rd(IFLAG_OFS);
         chk(rv, 32'h3);
         wr(IFLAG_OFS, 32'h2);
         rd(STATUS_OFS);
         chk(rv, 32'h100 | (32'h10 >> i));
         wr(STATUS_OFS, 32'h1c);
         rd(STATUS_OFS);
         chk(rv, 32'h100);
         chk(32'(irq_o), 32'h0);
      end
      @(posedge mclk_i);
      busy_i <= 1'b1;
      rd(IFLAG_OFS);
      chk(rv, 32'h0);
      wr(IENSET_OFS, 32'h1);
      chk(32'(irq_o), 32'h0);
      @(posedge mclk_i);
      busy_i <= 1'b0;
      @(negedge mclk_i);
      chk(32'(irq_o), 32'h1);
      wr(IENCLR_OFS, 32'h3);
      @(negedge mclk_i);
      chk(32'(irq_o), 32'h0);
      $display("interrupt done");
      sl(1'b1);
      chk(32'(power_reduced_o), 32'h0);
      sl(1'b0);
      wr(CONTROL_B_SETTINGS_OFS, 32'h080);
      sl(1'b1);
      chk(32'(power_reduced_o), 32'h1);
      sl(1'b0);
      chk(32'(power_reduced_o), 32'h1);
      pulse(9'h100);
      chk(32'(power_reduced_o), 32'h0);
      wr(CONTROL_B_SETTINGS_OFS, 32'h180);
      sl(1'b1);
      chk(32'(power_reduced_o), 32'h1);
      sl(1'b0);
      chk(32'(power_reduced_o), 32'h0);
      pulse(9'h040);
      rd(STATUS_OFS);
      chk(rv, 32'h101);
      pulse(9'h080);
      chk(32'(power_reduced_o), 32'h0);
      $display("power done");
      wr(IENSET_OFS, 32'h3);
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(CONTROL_B_SETTINGS_OFS);
      chk(rv, CONTROL_B_SETTINGS_RST);
      rd(IENSET_OFS);
      chk(rv, 32'h0);
      $display("reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
